/* src/flash_erase_write_control.sv */
/*
  Flash erase/write controller: APB register front end, unlock sequence,
  page erase and page write towards the flash array, CPU stall.
  Assumes a 40 MHz pclk, APB master, and a flash array that takes a page
  erase or a per-word program strobe and needs no handshake back.
*/
`timescale 1ns/10ps
module flash_erase_write_control
  import flash_ctl_pkg::*;
#(
  parameter int unsigned PROG_COUNT = PROG_CYCLES,
  parameter int unsigned UNLOCK_COUNT = UNLOCK_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cpu_stall,
  output logic flash_erase,
  output logic flash_prog,
  output logic [FADDR_W-1:0] flash_addr,
  output logic [15:0] flash_wdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG = 2'b10
  } op_state_t;

  flash_buf_if buf_bus ();

  flash_page_buffer u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .bus(buf_bus)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign pready = 1'b1;

  logic enabled_r, enabled_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic trigger_r, trigger_nxt;
  logic initiate_r, initiate_nxt;
  logic clear_r, clear_nxt;
  logic [7:0] alo_r, alo_nxt, ahi_r, ahi_nxt, d0l_r, d0l_nxt, d0h_r, d0h_nxt;
  logic [7:0] key_r [6];
  logic [7:0] key_nxt [6];
  logic [WORD_IDX_W-1:0] fill_r, fill_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic [31:0] ptimer_r, ptimer_nxt;
  logic [WORD_IDX_W-1:0] widx_r, widx_nxt;
  op_state_t st_r, st_nxt;
  logic [31:0] rdata_nxt;
  logic key_ok, slverr_nxt, mapped;
  logic [FADDR_W-1:0] faddr;

  localparam logic [ADDR_W-1:0] KEY_OFF [6] = '{OFF_K1L, OFF_K2L, OFF_K3L, OFF_K1H, OFF_K2H, OFF_K3H};
  localparam logic [7:0] KEY_VAL [6] = '{KEY1_LO, KEY2_LO, KEY3_LO, KEY1_HI, KEY2_HI, KEY3_HI};

  assign faddr = {ahi_r[4:0], alo_r};
  assign key_ok = (key_r[0] == KEY_VAL[0]) && (key_r[1] == KEY_VAL[1]) && (key_r[2] == KEY_VAL[2])
    && (key_r[3] == KEY_VAL[3]) && (key_r[4] == KEY_VAL[4]) && (key_r[5] == KEY_VAL[5]);

  always_comb begin
    mapped = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (hit(paddr, KEY_OFF[i])) begin
        mapped = 1'b1;
      end
    end
    if (hit(paddr, OFF_CTRL0) || hit(paddr, OFF_BUF_CLR) || hit(paddr, OFF_ADDR_LO) || hit(paddr, OFF_ADDR_HI)
        || hit(paddr, OFF_D0L) || hit(paddr, OFF_D0H) || hit(paddr, OFF_STATUS)) begin
      mapped = 1'b1;
    end
  end

  always_comb begin
    enabled_nxt = enabled_r;
    mode_nxt = mode_r;
    trigger_nxt = trigger_r;
    initiate_nxt = initiate_r;
    clear_nxt = clear_r;
    alo_nxt = alo_r;
    ahi_nxt = ahi_r;
    d0l_nxt = d0l_r;
    d0h_nxt = d0h_r;
    key_nxt = key_r;
    fill_nxt = fill_r;
    timer_nxt = timer_r;
    ptimer_nxt = ptimer_r;
    widx_nxt = widx_r;
    st_nxt = st_r;
    buf_bus.load = 1'b0;
    buf_bus.idx = fill_r;
    buf_bus.wdata = {d0h_r, d0l_r};
    // Software writes; stalled CPU cannot issue any during an operation
    if (wr_en && st_r == ST_IDLE) begin
      if (hit(paddr, OFF_CTRL0)) begin
        if (!pwdata[BIT_ENABLED]) begin
          enabled_nxt = 1'b0;
        end
        mode_nxt = pwdata[BIT_MODE_LO +: 3];
        if (pwdata[BIT_TRIGGER] && !trigger_r && pwdata[BIT_MODE_LO +: 3] == MODE_UNLOCK) begin
          trigger_nxt = 1'b1;
          timer_nxt = UNLOCK_COUNT;
          for (int i = 0; i < 6; i++) begin
            key_nxt[i] = ~KEY_VAL[i];
          end
        end
        if (pwdata[BIT_INITIATE] && !initiate_r) begin
          initiate_nxt = 1'b1;
        end
      end
      if (hit(paddr, OFF_BUF_CLR) && pwdata[BIT_CLEAR]) begin
        clear_nxt = 1'b1;
      end
      if (hit(paddr, OFF_ADDR_LO)) begin
        alo_nxt = pwdata[7:0];
        fill_nxt = pwdata[WORD_IDX_W-1:0];
      end
      if (hit(paddr, OFF_ADDR_HI)) begin
        ahi_nxt = pwdata[7:0] & ADDR_HI_MASK;
      end
      if (hit(paddr, OFF_D0L)) begin
        d0l_nxt = pwdata[7:0];
      end
      if (hit(paddr, OFF_D0H)) begin
        d0h_nxt = pwdata[7:0];
        buf_bus.load = 1'b1;
        buf_bus.wdata = {pwdata[7:0], d0l_r};
        if (fill_r != WORD_IDX_W'(PAGE_WORDS - 1)) begin
          fill_nxt = fill_r + 1'b1;
          {ahi_nxt[4:0], alo_nxt} = faddr + 1'b1;
        end
      end
      for (int i = 0; i < 6; i++) begin
        if (trigger_r && hit(paddr, KEY_OFF[i])) begin
          key_nxt[i] = pwdata[7:0];
        end
      end
    end
    // Unlock window
    if (trigger_r) begin
      if (timer_r <= 32'd1) begin
        trigger_nxt = 1'b0;
        enabled_nxt = key_ok;
      end else begin
        timer_nxt = timer_r - 32'd1;
      end
    end
    if (clear_r && buf_bus.clear_done) begin
      clear_nxt = 1'b0;
      fill_nxt = '0;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (initiate_r) begin
          if (!enabled_r || (mode_r != MODE_WRITE && mode_r != MODE_PAGE_ERASE)) begin
            initiate_nxt = 1'b0;
          end else begin
            ptimer_nxt = PROG_COUNT;
            widx_nxt = '0;
            st_nxt = (mode_r == MODE_PAGE_ERASE) ? ST_ERASE : ST_PROG;
          end
        end
      end
      ST_ERASE, ST_PROG: begin
        if (st_r == ST_PROG && widx_r != WORD_IDX_W'(PAGE_WORDS - 1)) begin
          widx_nxt = widx_r + 1'b1;
        end
        if (ptimer_r <= 32'd1) begin
          initiate_nxt = 1'b0;
          st_nxt = ST_IDLE;
        end else begin
          ptimer_nxt = ptimer_r - 32'd1;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  assign buf_bus.clear = clear_r;
  assign buf_bus.rd_idx = widx_r;

  always_comb begin
    rdata_nxt = '0;
    slverr_nxt = 1'b0;
    if (rd_en) begin
      if (hit(paddr, OFF_CTRL0)) begin
        rdata_nxt[BIT_ENABLED] = enabled_r;
        rdata_nxt[BIT_MODE_LO +: 3] = mode_r;
        rdata_nxt[BIT_TRIGGER] = trigger_r;
        rdata_nxt[BIT_INITIATE] = initiate_r;
      end
      if (hit(paddr, OFF_BUF_CLR)) begin
        rdata_nxt[BIT_CLEAR] = clear_r;
      end
      if (hit(paddr, OFF_ADDR_LO)) begin
        rdata_nxt[7:0] = alo_r;
      end
      if (hit(paddr, OFF_ADDR_HI)) begin
        rdata_nxt[7:0] = ahi_r;
      end
      if (hit(paddr, OFF_D0L)) begin
        rdata_nxt[7:0] = d0l_r;
      end
      if (hit(paddr, OFF_D0H)) begin
        rdata_nxt[7:0] = d0h_r;
      end
      for (int i = 0; i < 6; i++) begin
        if (hit(paddr, KEY_OFF[i])) begin
          rdata_nxt[7:0] = key_r[i];
        end
      end
      if (hit(paddr, OFF_STATUS)) begin
        rdata_nxt[WORD_IDX_W-1:0] = fill_r;
      end
      slverr_nxt = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled_r <= 1'b0;
      mode_r <= 3'b000;
      trigger_r <= 1'b0;
      initiate_r <= 1'b0;
      clear_r <= 1'b0;
      alo_r <= 8'h00;
      ahi_r <= 8'h00;
      d0l_r <= 8'h00;
      d0h_r <= 8'h00;
      for (int i = 0; i < 6; i++) begin
        key_r[i] <= 8'hff;
      end
      fill_r <= '0;
      timer_r <= '0;
      ptimer_r <= '0;
      widx_r <= '0;
      st_r <= ST_IDLE;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      enabled_r <= enabled_nxt;
      mode_r <= mode_nxt;
      trigger_r <= trigger_nxt;
      initiate_r <= initiate_nxt;
      clear_r <= clear_nxt;
      alo_r <= alo_nxt;
      ahi_r <= ahi_nxt;
      d0l_r <= d0l_nxt;
      d0h_r <= d0h_nxt;
      key_r <= key_nxt;
      fill_r <= fill_nxt;
      timer_r <= timer_nxt;
      ptimer_r <= ptimer_nxt;
      widx_r <= widx_nxt;
      st_r <= st_nxt;
      prdata <= rdata_nxt;
      pslverr <= slverr_nxt;
    end
  end

  // Flash array side; page base from bits 12..5, whole page erased
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_erase <= 1'b0;
      flash_prog <= 1'b0;
      flash_addr <= '0;
      flash_wdata <= '0;
    end else begin
      flash_erase <= (st_r == ST_ERASE);
      flash_prog <= (st_r == ST_PROG) && (ptimer_r > PROG_COUNT - PAGE_WORDS);
      flash_addr <= (st_r == ST_PROG) ? {faddr[FADDR_W-1:WORD_IDX_W], widx_r} : {faddr[FADDR_W-1:WORD_IDX_W], 5'h00};
      flash_wdata <= buf_bus.rd_data;
    end
  end

  // Stall also covers the last cycle of the registered flash strobes
  assign cpu_stall = (st_r != ST_IDLE) || flash_erase || flash_prog;
endmodule

/* src/flash_ctl_pkg.sv */
/*
  Package for the flash erase/write controller: register map, field positions,
  mode codes, unlock key and timing constants.
  Assumes a 40 MHz APB clock and 32-bit APB data with one register per word.
*/
package flash_ctl_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_BUF_CLR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ADDR_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ADDR_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_D0L = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_D0H = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_K1L = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_K1H = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_K2L = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_K2H = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_K3L = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_K3H = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h30;

  localparam int unsigned BIT_ENABLED = 7;
  localparam int unsigned BIT_MODE_LO = 4;
  localparam int unsigned BIT_TRIGGER = 3;
  localparam int unsigned BIT_INITIATE = 2;
  localparam int unsigned BIT_CLEAR = 0;

  typedef enum logic [2:0] {
    MODE_WRITE = 3'b000,
    MODE_PAGE_ERASE = 3'b001,
    MODE_READ = 3'b011,
    MODE_UNLOCK = 3'b110
  } op_mode_t;

  localparam logic [7:0] KEY1_LO = 8'h00;
  localparam logic [7:0] KEY2_LO = 8'h0d;
  localparam logic [7:0] KEY3_LO = 8'hc3;
  localparam logic [7:0] KEY1_HI = 8'h04;
  localparam logic [7:0] KEY2_HI = 8'h09;
  localparam logic [7:0] KEY3_HI = 8'h40;

  localparam int unsigned PAGE_WORDS = 32;
  localparam int unsigned WORD_IDX_W = 5;
  localparam int unsigned FADDR_W = 13;
  localparam logic [7:0] ADDR_HI_MASK = 8'h1f;
  localparam logic [15:0] BUF_INIT = 16'h0000;

  localparam int unsigned PROG_TIME_US = 2200;
  localparam int unsigned PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1000000);
  localparam int unsigned UNLOCK_TIME_US = 1000;
  localparam int unsigned UNLOCK_CYCLES = UNLOCK_TIME_US * (CLK_HZ / 1000000);
endpackage

/* src/flash_ctl_if.sv */
/*
  Interface between the register front end and the page write buffer.
  Assumes both sides run on pclk.
*/
`timescale 1ns/10ps
interface flash_buf_if;
  import flash_ctl_pkg::*;
  logic load;
  logic [WORD_IDX_W-1:0] idx;
  logic [15:0] wdata;
  logic clear;
  logic clear_done;
  logic [WORD_IDX_W-1:0] rd_idx;
  logic [15:0] rd_data;
  modport ctrl (output load, idx, wdata, clear, rd_idx, input clear_done, rd_data);
  modport buffer (input load, idx, wdata, clear, rd_idx, output clear_done, rd_data);
endinterface

/* src/flash_page_buffer.sv */
/*
  Page write buffer of 32 words with a word-by-word clear sweep.
  Assumes the controller drives load, clear and read index on pclk.
*/
`timescale 1ns/10ps
module flash_page_buffer
  import flash_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  flash_buf_if.buffer bus
);
  logic [15:0] mem [PAGE_WORDS];
  logic clearing_r, clearing_nxt;
  logic [WORD_IDX_W-1:0] sweep_r, sweep_nxt;

  always_comb begin
    clearing_nxt = clearing_r;
    sweep_nxt = sweep_r;
    if (bus.clear && !clearing_r) begin
      clearing_nxt = 1'b1;
      sweep_nxt = '0;
    end else if (clearing_r) begin
      sweep_nxt = sweep_r + 1'b1;
      if (sweep_r == WORD_IDX_W'(PAGE_WORDS - 1)) begin
        clearing_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clearing_r <= 1'b0;
      sweep_r <= '0;
    end else begin
      clearing_r <= clearing_nxt;
      sweep_r <= sweep_nxt;
    end
  end

  // Every word returns to its initial value
  always_ff @(posedge pclk) begin
    if (clearing_r) begin
      mem[sweep_r] <= BUF_INIT;
    end else if (bus.load) begin
      mem[bus.idx] <= bus.wdata;
    end
  end

  assign bus.clear_done = clearing_r && (sweep_r == WORD_IDX_W'(PAGE_WORDS - 1));
  assign bus.rd_data = mem[bus.rd_idx];
endmodule

/* bench/flash_array_model.sv */
/*
  Behavioural model of the flash array behind the erase/write controller.
  Assumes erase and program strobes are sampled on the rising edge of pclk.
*/
`timescale 1ns/10ps
module flash_array_model
  import flash_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic [FADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_wdata
);
  logic [15:0] mem [0:(1<<FADDR_W)-1];

  // Unwritten cells differ from the erased value
  initial begin
    for (int i = 0; i < (1 << FADDR_W); i++) begin
      mem[i] = 16'hffff;
    end
  end

  always @(posedge pclk) begin
    if (flash_erase) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        mem[{flash_addr[FADDR_W-1:5], i[4:0]}] <= 16'h0000;
      end
    end else if (flash_prog) begin
      mem[flash_addr] <= flash_wdata;
    end
  end
endmodule

/* bench/flash_erase_write_control_props.sv */
/*
  Port properties of the flash erase/write controller.
  Assumes it is bound to flash_erase_write_control and sees only its ports.
*/
`timescale 1ns/10ps
module flash_ctl_props
  import flash_ctl_pkg::*;
#(
  parameter int unsigned PROG_COUNT = PROG_CYCLES,
  parameter int unsigned UNLOCK_COUNT = UNLOCK_CYCLES
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cpu_stall,
  input wire logic flash_erase,
  input wire logic flash_prog,
  input wire logic [FADDR_W-1:0] flash_addr,
  input wire logic [15:0] flash_wdata
);
  logic [31:0] stall_cnt_r;
  logic [31:0] stall_cnt_nxt;
  logic [4:0] word_idx;

  assign word_idx = flash_addr[4:0];

  always_comb begin
    stall_cnt_nxt = cpu_stall ? stall_cnt_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_r <= 32'h0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stall_erase; flash_erase |-> cpu_stall; endproperty
  property p_stall_prog; flash_prog |-> cpu_stall; endproperty
  property p_erase_base; flash_erase |-> word_idx == 5'h00; endproperty
  property p_erase_hold; flash_erase && $past(flash_erase) |-> $stable(flash_addr); endproperty
  property p_prog_start; $rose(flash_prog) |-> word_idx == 5'h00; endproperty
  property p_prog_step; flash_prog && $past(flash_prog) |-> flash_addr == $past(flash_addr) + 13'h1; endproperty
  property p_prog_last; $fell(flash_prog) |-> $past(word_idx) == 5'h1f; endproperty
  property p_stall_len;
    $fell(cpu_stall) |-> stall_cnt_r + 32'h3 >= PROG_COUNT && stall_cnt_r <= PROG_COUNT + 3;
  endproperty
  property p_unmapped;
    psel && penable && !pwrite && paddr > OFF_STATUS |-> pslverr && prdata == 32'h0;
  endproperty

  a_stall_erase: assert property (p_stall_erase) else $error("stall low during erase");
  a_stall_prog: assert property (p_stall_prog) else $error("stall low during program");
  a_erase_base: assert property (p_erase_base) else $error("erase not page aligned");
  a_erase_hold: assert property (p_erase_hold) else $error("erase address moved");
  a_prog_start: assert property (p_prog_start) else $error("program not from word zero");
  a_prog_step: assert property (p_prog_step) else $error("program address skipped");
  a_prog_last: assert property (p_prog_last) else $error("program not ended at word 31");
  a_stall_len: assert property (p_stall_len) else $error("busy span wrong length");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");

  c_erase: cover property ($rose(flash_erase));
  c_prog: cover property ($rose(flash_prog));
  c_unmapped: cover property (psel && penable && pslverr);
endmodule

bind flash_erase_write_control flash_ctl_props #(.PROG_COUNT(PROG_COUNT), .UNLOCK_COUNT(UNLOCK_COUNT))
  u_flash_ctl_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_prog(flash_prog),
  .flash_addr(flash_addr), .flash_wdata(flash_wdata));

/* bench/flash_erase_write_control_test.sv */
/*
  Self-checking bench for the flash erase/write controller over APB.
  Assumes the flash array model on the far side and the bound checker.
*/
`timescale 1ns/10ps
module flash_erase_write_control_test
  import flash_ctl_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, cpu_stall, flash_erase, flash_prog;
  logic [FADDR_W-1:0] flash_addr;
  logic [15:0] flash_wdata;
  int n_errors = 0;
  int checks_done = 0;

  always #12.5 pclk = ~pclk;

  flash_erase_write_control #(.PROG_COUNT(64), .UNLOCK_COUNT(50)) u_flash_erase_write_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_stall(cpu_stall),
    .flash_erase(flash_erase), .flash_prog(flash_prog), .flash_addr(flash_addr), .flash_wdata(flash_wdata));
  flash_array_model u_flash_array_model (.pclk(pclk), .flash_erase(flash_erase), .flash_prog(flash_prog),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      xfer(1'b0, a, 32'h0);
      n++;
    end while ((q & m) !== 32'h0 && n < 200);
    chk("self-clearing bit", 32'h0, q & m);
  endtask

  task automatic unlock(input logic [7:0] bad);
    logic [7:0] key [6];
    key = '{KEY1_LO, KEY1_HI, KEY2_LO, KEY2_HI, KEY3_LO, KEY3_HI};
    xfer(1'b1, OFF_CTRL0, 32'h68);
    xfer(1'b0, OFF_CTRL0, 32'h0);
    chk("trigger", 32'h8, q & 32'h8);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b1, OFF_K1L + 8'(4 * i), {24'h0, key[i] ^ ((i == 5) ? bad : 8'h00)});
    end
    poll(OFF_CTRL0, 32'h8);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    test_done;
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b1, OFF_BUF_CLR, 32'hfe);
    xfer(1'b0, OFF_BUF_CLR, 32'h0);
    chk("clear reg", 32'h0, q);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test reset done");
    xfer(1'b1, OFF_CTRL0, 32'h80);
    xfer(1'b1, OFF_CTRL0, 32'h04);
    repeat (4) @(posedge pclk);
    xfer(1'b0, OFF_CTRL0, 32'h0);
    chk("ctrl disabled", 32'h0, q & 32'h84);
    chk("flash untouched", 32'hffff, {16'h0, u_flash_array_model.mem[0]});
    $display("test disabled done");
    unlock(8'h01);
    chk("enable bad key", 32'h0, q & 32'h80);
    unlock(8'h00);
    chk("enable good key", 32'h80, q & 32'h80);
    xfer(1'b1, OFF_CTRL0, 32'hb4);
    repeat (4) @(posedge pclk);
    xfer(1'b0, OFF_CTRL0, 32'h0);
    chk("initiate refused in read mode", 32'h80, q & 32'h84);
    chk("flash untouched read mode", 32'hffff, {16'h0, u_flash_array_model.mem[13'h140]});
    $display("test unlock done");
    xfer(1'b1, OFF_ADDR_HI, 32'h01);
    xfer(1'b1, OFF_ADDR_LO, 32'h40);
    xfer(1'b1, OFF_CTRL0, 32'h94);
    poll(OFF_CTRL0, 32'h4);
    for (int i = 0; i < 34; i++) begin
      chk("erased word", (i == 0 || i == 33) ? 32'hffff : 32'h0, {16'h0, u_flash_array_model.mem[13'h13f + i]});
    end
    $display("test erase done");
    for (int i = 0; i < 33; i++) begin
      xfer(1'b1, OFF_D0L, i);
      xfer(1'b1, OFF_D0H, 32'h10);
      if (i == 0) begin
        xfer(1'b0, OFF_STATUS, 32'h0);
        chk("fill index", 32'h1, q);
      end
    end
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("fill saturated", 32'h1f, q);
    xfer(1'b0, OFF_ADDR_LO, 32'h0);
    chk("address advanced", 32'h5f, q);
    xfer(1'b1, OFF_CTRL0, 32'h84);
    poll(OFF_CTRL0, 32'h4);
    for (int i = 0; i < 32; i++) begin
      chk("programmed word", 32'h1000 + ((i == 31) ? 32 : i), {16'h0, u_flash_array_model.mem[13'h140 + i]});
    end
    $display("test write done");
    xfer(1'b1, OFF_BUF_CLR, 32'h1);
    poll(OFF_BUF_CLR, 32'h1);
    xfer(1'b0, OFF_STATUS, 32'h0);
    chk("fill after clear", 32'h0, q);
    xfer(1'b1, OFF_ADDR_LO, 32'h40);
    xfer(1'b1, OFF_D0L, 32'h5a);
    xfer(1'b1, OFF_D0H, 32'h0a);
    xfer(1'b1, OFF_CTRL0, 32'h84);
    poll(OFF_CTRL0, 32'h4);
    chk("rewritten word", 32'h0a5a, {16'h0, u_flash_array_model.mem[13'h140]});
    chk("cleared word", 32'h0, {16'h0, u_flash_array_model.mem[13'h141]});
    $display("test rewrite done");
    xfer(1'b1, OFF_CTRL0, 32'h00);
    xfer(1'b0, OFF_CTRL0, 32'h0);
    chk("disabled", 32'h0, q & 32'h80);
    $display("test disable done");
    test_done;
  end
endmodule
